/* File: verilog/mdt_pkg.sv */
// Package: opcodes, addressing codes, condition codes and cycle counts of the decoder
package mdt_pkg;

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  localparam logic [3:0] HI_COMPLEMENT_MASK_TEST = 4'h6;
  localparam logic [3:0] HI_MASK_TEST            = 4'h7;
  localparam logic [3:0] LO_WW                   = 4'h2;
  localparam logic [3:0] LO_WI                   = 4'h3;
  localparam logic [3:0] LO_RR                   = 4'h4;
  localparam logic [3:0] LO_RI                   = 4'h5;
  localparam logic [3:0] LO_RIM                  = 4'h6;
  localparam logic [3:0] LO_IIM                  = 4'h7;
  localparam logic [3:0] LO_DECREMENT_BRANCH_NONZERO                 = 4'hA;
  localparam logic [3:0] LO_JR                   = 4'hB;
  localparam logic [3:0] LO_JP                   = 4'hD;

  localparam logic [7:0] OP_PM_LOAD       = 8'hC2;
  localparam logic [7:0] OP_PM_LOAD_AI    = 8'hC3;
  localparam logic [7:0] OP_PM_STORE      = 8'hD2;
  localparam logic [7:0] OP_PM_STORE_AI   = 8'hD3;
  localparam logic [7:0] OP_XD_LOAD       = 8'h82;
  localparam logic [7:0] OP_XD_LOAD_AI    = 8'h83;
  localparam logic [7:0] OP_XD_STORE      = 8'h92;
  localparam logic [7:0] OP_XD_STORE_AI   = 8'h93;
  localparam logic [7:0] OP_SUB_EXIT      = 8'hAF;
  localparam logic [7:0] OP_STACK_PUSH_R  = 8'h70;
  localparam logic [7:0] OP_STACK_PUSH_IR = 8'h71;
  localparam logic [7:0] OP_CALL_IND      = 8'hD4;
  localparam logic [7:0] OP_CALL_DA       = 8'hD6;
  localparam logic [7:0] OP_NOP           = 8'hFF;

  // ---------------------------------------------------------------
  // Condition codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CC_NEVER  = 4'h0;
  localparam logic [3:0] CC_ALWAYS = 4'h8;

  // ---------------------------------------------------------------
  // Cycle counts (input clock periods), pipeline counts, lengths and pointer steps
  // ---------------------------------------------------------------
  localparam logic [4:0] CYC_6      = 5'h06;
  localparam logic [4:0] CYC_10     = 5'h0A;
  localparam logic [4:0] CYC_12     = 5'h0C;
  localparam logic [4:0] CYC_14     = 5'h0E;
  localparam logic [4:0] CYC_18     = 5'h12;
  localparam logic [4:0] CYC_20     = 5'h14;
  localparam logic [4:0] CYC_ZERO   = 5'h00;
  localparam logic [2:0] PIPE_0     = 3'h0;
  localparam logic [2:0] PIPE_1     = 3'h1;
  localparam logic [2:0] PIPE_5     = 3'h5;
  localparam logic [1:0] LEN_2      = 2'h2;
  localparam logic [1:0] LEN_3      = 2'h3;
  localparam logic [7:0] SP_RET_ADD = 8'h02;
  localparam logic [7:0] SP_PUSH_DEC = 8'h01;
  localparam logic [7:0] PTR_INC    = 8'h01;
  localparam logic [2:0] EXT_STRETCH = 3'h2;

  typedef enum {
    MDT_IDLE,
    MDT_EXEC
  } mdt_state_t;

endpackage

/* File: verilog/mdt_cond_eval.sv */
// Condition-code evaluator for conditional jumps and branches
`timescale 1ns/1ps
module mdt_cond_eval
  import mdt_pkg::*;
(
  input  wire logic [3:0] cond_in,
  input  wire logic       carry_in,
  input  wire logic       zero_in,
  input  wire logic       sign_in,
  input  wire logic       ovf_in,
  output logic            true_out
);
  // ---------------------------------------------------------------
  // Evaluation
  // ---------------------------------------------------------------
  // Low three bits pick the test, bit 3 inverts it; code 0 is never, 8 always
  logic base;
  always_comb begin
    base = 1'b0;
    case (cond_in[2:0])
      3'd0: base = 1'b0;
      3'd1: base = sign_in ^ ovf_in;
      3'd2: base = zero_in | (sign_in ^ ovf_in);
      3'd3: base = carry_in | zero_in;
      3'd4: base = ovf_in;
      3'd5: base = sign_in;
      3'd6: base = zero_in;
      default: base = carry_in;
    endcase
    true_out = base ^ cond_in[3]; // see RL13
  end
endmodule

/* File: verilog/mdt_decode.sv */
// Opcode decoder with execution timing, flag effects and external memory stretch
`timescale 1ns/1ps
// Summary of operation
// RL1: Complement-mask test (6x) ands inverted dst with src, mask test (7x) ands them; Z,S set, V cleared, C kept, no result.
// RL2: Opcode C2 is the program-memory load and takes 12 cycles; its auto-increment form takes 18.
// RL3: Opcode C3 is the auto-increment program-memory load, incrementing both pointers after the copy.
// RL4: Opcode 82 is the external-data load taking 12 cycles; its auto-increment form takes 18.
// RL5: Two-operand operations share low-nibble codes 2..7 for the six addressing modes.
// RL6: Opcode AF loads the PC from the stack, adds two to the stack pointer, and takes 14 cycles.
// RL7: Opcode 70/71 decrements the stack pointer then stores, taking 10/12 or 12/14 cycles.
// RL8: Decrement-branch and relative jump take 12 if taken else 10, with 5 and 0 pipeline cycles.
// RL9: Blank opcode positions are undefined; here they are flagged and act as a no-operation.
// RL10: Opcode D4 is two bytes but fetches as three; both call forms take 20 cycles.
// RL11: Extended memory timing stretches each external access by two input clock periods; pushes to an external stack are not stretched.
// RL12: A raised level on reset forces external memory mode for program fetch.
// RL13: Conditions use a 4-bit field, 1000 always, 0000 never, others test flags.
module mdt_decode
  import mdt_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       issue_in,       // One-cycle request: decode opcode_in
  input  wire logic [7:0] opcode_in,
  input  wire logic       carry_in,
  input  wire logic       zero_in,
  input  wire logic       sign_in,
  input  wire logic       ovf_in,
  input  wire logic [7:0] dst_in,
  input  wire logic [7:0] src_in,
  input  wire logic [7:0] stack_ptr_in,
  input  wire logic [7:0] reg_ptr_in,
  input  wire logic [7:0] pair_ptr_in,
  input  wire logic       count_nz_in,    // Decremented counter is nonzero
  input  wire logic       ext_timing_in,  // Extended memory timing selected
  input  wire logic       reset_high_in,  // Raised level on reset pin (asynchronous)
  output logic            busy_out,
  output logic            done_out,
  output logic [4:0]      cycles_out,
  output logic [2:0]      pipe_out,
  output logic [1:0]      length_out,
  output logic            undefined_out,
  output logic            taken_out,
  output logic            test_only_out,
  output logic            zero_out,
  output logic            sign_out,
  output logic            ovf_out,
  output logic            carry_out,
  output logic [7:0]      stack_ptr_out,
  output logic [7:0]      reg_ptr_out,
  output logic [7:0]      pair_ptr_out,
  output logic [2:0]      stretch_out,
  output logic            ext_mode_out
);
  import mdt_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Two-operand addressing code check, shared by several decodes
  function automatic logic is_twoop_lo(input logic [3:0] lo);
    is_twoop_lo = (lo >= LO_WW) && (lo <= LO_IIM); // see RL5
  endfunction

  function automatic logic is_ext_access(input logic [7:0] op);
    is_ext_access = (op == OP_PM_LOAD) || (op == OP_PM_LOAD_AI) || (op == OP_PM_STORE) ||
                    (op == OP_PM_STORE_AI) || (op == OP_XD_LOAD) || (op == OP_XD_LOAD_AI) ||
                    (op == OP_XD_STORE) || (op == OP_XD_STORE_AI);
  endfunction

  logic cond_true;
  mdt_cond_eval u_cond (
    .cond_in  (opcode_in[7:4]),
    .carry_in (carry_in),
    .zero_in  (zero_in),
    .sign_in  (sign_in),
    .ovf_in   (ovf_in),
    .true_out (cond_true)
  );

  // ---------------------------------------------------------------
  // Reset-pin mode capture (three-stage synchroniser)
  // ---------------------------------------------------------------
  logic [2:0] rh_sync_r, rh_sync_nxt;
  logic       ext_mode_r, ext_mode_nxt;
  always_comb begin
    rh_sync_nxt  = {rh_sync_r[1:0], reset_high_in};
    ext_mode_nxt = ext_mode_r;
    // Second and third stage agree; the first stage feeds nothing else
    if (rh_sync_r[1] == rh_sync_r[2]) begin
      ext_mode_nxt = ext_mode_r | rh_sync_r[2]; // see RL12
    end
  end
  // Mode is sticky: only a clean reset without the raised level clears it
  always_ff @(posedge clock_in) begin
    if (rst_in && !(rh_sync_r[1] & rh_sync_r[2])) begin
      rh_sync_r  <= rh_sync_nxt;
      ext_mode_r <= 1'b0;
    end else begin
      rh_sync_r  <= rh_sync_nxt;
      ext_mode_r <= ext_mode_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [3:0] hi, lo;
  logic [4:0] dcyc;
  logic [2:0] dpipe;
  logic [1:0] dlen;
  logic       dundef, dtaken, dtest;
  logic [7:0] dsp, drp, dpp;
  logic       dz, ds, dv;
  logic [7:0] tres;
  always_comb begin
    hi     = opcode_in[7:4];
    lo     = opcode_in[3:0];
    dcyc   = CYC_6;
    dpipe  = PIPE_5;
    dlen   = LEN_2;
    dundef = 1'b0;
    dtaken = 1'b0;
    dtest  = 1'b0;
    dsp    = stack_ptr_in;
    drp    = reg_ptr_in;
    dpp    = pair_ptr_in;
    dz     = zero_in;
    ds     = sign_in;
    dv     = ovf_in;
    tres   = (hi == HI_COMPLEMENT_MASK_TEST) ? (~dst_in & src_in) : (dst_in & src_in);
    if ((hi == HI_COMPLEMENT_MASK_TEST || hi == HI_MASK_TEST) && is_twoop_lo(lo)) begin
      dtest = 1'b1; // No result is written back; see RL1
      dz    = (tres == 8'h00);
      ds    = tres[7];
      dv    = 1'b0;
      dcyc  = (lo >= LO_RR) ? CYC_10 : CYC_6;
      dlen  = (lo >= LO_RR) ? LEN_3 : LEN_2; // Same modes as other two-operand ops; see RL5
    end else if (opcode_in == OP_PM_LOAD || opcode_in == OP_PM_STORE ||
                 opcode_in == OP_XD_LOAD || opcode_in == OP_XD_STORE) begin
      dcyc  = CYC_12; // see RL2 RL4
      dpipe = PIPE_0;
    end else if (opcode_in == OP_PM_LOAD_AI || opcode_in == OP_PM_STORE_AI ||
                 opcode_in == OP_XD_LOAD_AI || opcode_in == OP_XD_STORE_AI) begin
      dcyc  = CYC_18; // see RL2 RL4
      dpipe = PIPE_0;
      drp   = reg_ptr_in + PTR_INC; // see RL3
      dpp   = pair_ptr_in + PTR_INC; // see RL3
    end else if (opcode_in == OP_SUB_EXIT) begin
      dcyc  = CYC_14; // see RL6
      dpipe = PIPE_0;
      dlen  = 2'h1;
      dsp   = stack_ptr_in + SP_RET_ADD; // see RL6
    end else if (opcode_in == OP_STACK_PUSH_R || opcode_in == OP_STACK_PUSH_IR) begin
      // Internal stack unless ext_mode_r is set; external stack adds two cycles
      dcyc  = (opcode_in == OP_STACK_PUSH_R) ? (ext_mode_r ? CYC_12 : CYC_10)
                                             : (ext_mode_r ? CYC_14 : CYC_12); // see RL7
      dpipe = PIPE_1;
      dsp   = stack_ptr_in - SP_PUSH_DEC; // see RL7
    end else if (opcode_in == OP_CALL_IND || opcode_in == OP_CALL_DA) begin
      dcyc  = CYC_20; // see RL10
      dpipe = PIPE_0;
      dlen  = LEN_3; // Indirect call fetches as three bytes; see RL10
      dsp   = stack_ptr_in - SP_RET_ADD;
    end else if (lo == LO_DECREMENT_BRANCH_NONZERO) begin
      dtaken = count_nz_in;
      dcyc   = count_nz_in ? CYC_12 : CYC_10; // see RL8
      dpipe  = PIPE_5;
    end else if (lo == LO_JR) begin
      dtaken = cond_true; // see RL13
      dcyc   = cond_true ? CYC_12 : CYC_10; // see RL8
      dpipe  = PIPE_0;
    end else if (lo == LO_JP) begin
      dtaken = cond_true; // see RL13
      dcyc   = cond_true ? CYC_12 : CYC_10;
      dpipe  = PIPE_0;
      dlen   = LEN_3;
    end else if (is_twoop_lo(lo) && hi != 4'h8 && hi != 4'h9 && hi != 4'hC && hi != 4'hD) begin
      dcyc = (lo >= LO_RR) ? CYC_10 : CYC_6; // see RL5
      dlen = (lo >= LO_RIM || lo == LO_RR || lo == LO_RI) ? LEN_3 : LEN_2;
    end else if (opcode_in == OP_NOP) begin
      dlen = 2'h1;
      dpipe = PIPE_0;
    end else begin
      // Outside this decoder's set: reported, no state changes
      dundef = 1'b1; // see RL9
      dcyc   = CYC_6;
    end
  end

  // ---------------------------------------------------------------
  // Execution timer and result registers
  // ---------------------------------------------------------------
  mdt_state_t state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic       done_r, done_nxt, busy_r, busy_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  logic [2:0] pipe_r, pipe_nxt, str_r, str_nxt;
  logic [1:0] len_r, len_nxt;
  logic       und_r, und_nxt, tak_r, tak_nxt, tst_r, tst_nxt;
  logic       z_r, z_nxt, s_r, s_nxt, v_r, v_nxt, c_r, c_nxt;
  logic [7:0] sp_r, sp_nxt, rp_r, rp_nxt, pp_r, pp_nxt;
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    {cyc_nxt, pipe_nxt, str_nxt, len_nxt} = {cyc_r, pipe_r, str_r, len_r};
    {und_nxt, tak_nxt, tst_nxt} = {und_r, tak_r, tst_r};
    {z_nxt, s_nxt, v_nxt, c_nxt} = {z_r, s_r, v_r, c_r};
    {sp_nxt, rp_nxt, pp_nxt} = {sp_r, rp_r, pp_r};
    case (state_r)
      MDT_IDLE: begin
        if (issue_in) begin
          cyc_nxt  = dcyc;
          // Stretch only when the op touches external memory; see RL11
          str_nxt  = (ext_timing_in && is_ext_access(opcode_in)) ? EXT_STRETCH : 3'h0;
          cnt_nxt  = dcyc + ((ext_timing_in && is_ext_access(opcode_in))
                             ? {2'b00, EXT_STRETCH} : CYC_ZERO) - 5'h01; // see RL11
          pipe_nxt = dpipe;
          len_nxt  = dlen;
          und_nxt  = dundef;
          tak_nxt  = dtaken;
          tst_nxt  = dtest;
          z_nxt    = dz;
          s_nxt    = ds;
          v_nxt    = dv;
          c_nxt    = carry_in; // Carry untouched by tests; see RL1
          sp_nxt   = dsp;
          rp_nxt   = drp;
          pp_nxt   = dpp;
          state_nxt = MDT_EXEC;
        end
      end
      default: begin
        if (cnt_r == 5'h01) begin
          done_nxt  = 1'b1;
          state_nxt = MDT_IDLE;
        end
        cnt_nxt = cnt_r - 5'h01;
      end
    endcase
    busy_nxt = (state_nxt == MDT_EXEC); // Registered so busy_out leaves a flip-flop
  end
  // Register stage only
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= MDT_IDLE;
      cnt_r   <= CYC_ZERO;
      {done_r, busy_r} <= 2'b00;
      {cyc_r, pipe_r, str_r, len_r} <= '0;
      {und_r, tak_r, tst_r} <= '0;
      {z_r, s_r, v_r, c_r} <= '0;
      {sp_r, rp_r, pp_r} <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      {done_r, busy_r} <= {done_nxt, busy_nxt};
      {cyc_r, pipe_r, str_r, len_r} <= {cyc_nxt, pipe_nxt, str_nxt, len_nxt};
      {und_r, tak_r, tst_r} <= {und_nxt, tak_nxt, tst_nxt};
      {z_r, s_r, v_r, c_r} <= {z_nxt, s_nxt, v_nxt, c_nxt};
      {sp_r, rp_r, pp_r} <= {sp_nxt, rp_nxt, pp_nxt};
    end
  end

  assign busy_out      = busy_r;
  assign done_out      = done_r;
  assign cycles_out    = cyc_r;
  assign pipe_out      = pipe_r;
  assign length_out    = len_r;
  assign undefined_out = und_r;
  assign taken_out     = tak_r;
  assign test_only_out = tst_r;
  assign zero_out      = z_r;
  assign sign_out      = s_r;
  assign ovf_out       = v_r;
  assign carry_out     = c_r;
  assign stack_ptr_out = sp_r;
  assign reg_ptr_out   = rp_r;
  assign pair_ptr_out  = pp_r;
  assign stretch_out   = str_r;
  assign ext_mode_out  = ext_mode_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  test_flags_a: assert property (issue_in && !busy_out && opcode_in[7:4] == HI_MASK_TEST &&
      opcode_in[3:0] == LO_WW |=> ovf_out == 1'b0 && test_only_out && carry_out == $past(carry_in)) // see RL1
    else $error("mask test flags wrong");
  pm_load_a: assert property (issue_in && !busy_out && opcode_in == OP_PM_LOAD |=> cycles_out == CYC_12) // see RL2
    else $error("program load cycles wrong");
  autoinc_a: assert property (issue_in && !busy_out && opcode_in == OP_PM_LOAD_AI
      |=> reg_ptr_out == $past(reg_ptr_in) + 8'h01 && pair_ptr_out == $past(pair_ptr_in) + 8'h01) // see RL3
    else $error("autoincrement wrong");
  xd_load_a: assert property (issue_in && !busy_out && opcode_in == OP_XD_LOAD_AI |=> cycles_out == CYC_18) // see RL4
    else $error("external load cycles wrong");
  sub_exit_a: assert property (issue_in && !busy_out && opcode_in == OP_SUB_EXIT && !ext_timing_in
      |=> stack_ptr_out == $past(stack_ptr_in) + 8'h02 ##13 done_out) // see RL6
    else $error("return timing wrong");
  push_sp_a: assert property (issue_in && !busy_out && opcode_in == OP_STACK_PUSH_R
      |=> stack_ptr_out == $past(stack_ptr_in) - 8'h01 && pipe_out == PIPE_1) // see RL7
    else $error("push pointer wrong");
  jr_time_a: assert property (issue_in && !busy_out && opcode_in[3:0] == LO_JR
      |=> cycles_out == (taken_out ? CYC_12 : CYC_10) && pipe_out == PIPE_0) // see RL8
    else $error("relative jump timing wrong");
  call_len_a: assert property (issue_in && !busy_out && opcode_in == OP_CALL_IND
      |=> length_out == LEN_3 && cycles_out == CYC_20) // see RL10
    else $error("indirect call wrong");
  stretch_a: assert property (issue_in && !busy_out && ext_timing_in && opcode_in == OP_PM_LOAD
      |=> busy_out [*8] ##6 done_out) // see RL11
    else $error("stretch missing");
  never_cc_a: assert property (issue_in && !busy_out && opcode_in == 8'h0B |=> !taken_out) // see RL13
    else $error("never condition taken");
  undef_a: assert property (issue_in && !busy_out && opcode_in == 8'h84 |=> undefined_out) // see RL9
    else $error("blank opcode not flagged");

  cov_ret_c:   cover property (issue_in && opcode_in == OP_SUB_EXIT ##14 done_out);
  cov_jr_c:    cover property (issue_in && opcode_in[3:0] == LO_JR ##1 taken_out);
  cov_ext_c:   cover property (ext_mode_out);
  cov_tcm_c:   cover property (issue_in && opcode_in[7:4] == HI_COMPLEMENT_MASK_TEST);
endmodule

/* File: sim/mdt_ctx_model.sv */
// Context model: pointer registers of the core that feed the decoder
`timescale 1ns/1ps
module mdt_ctx_model #(
  parameter logic [7:0] SP_INIT = 8'h40,
  parameter logic [7:0] RP_INIT = 8'h10,
  parameter logic [7:0] PP_INIT = 8'h20
) (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       commit_in,  // Write results back when high
  input  wire logic       done_in,
  input  wire logic [7:0] sp_new_in,
  input  wire logic [7:0] rp_new_in,
  input  wire logic [7:0] pp_new_in,
  output logic      [7:0] sp_out,
  output logic      [7:0] rp_out,
  output logic      [7:0] pp_out
);
  // Pointers move only when an operation finishes, so a read taken at
  // the done edge itself still sees the old value: callers wait a cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sp_out <= SP_INIT;
      rp_out <= RP_INIT;
      pp_out <= PP_INIT;
    end else if (done_in && commit_in) begin
      sp_out <= sp_new_in;
      rp_out <= rp_new_in;
      pp_out <= pp_new_in;
    end
  end
endmodule

/* File: sim/mdt_decode_tb.sv */
// Testbench for the opcode decoder and its execution timing
`timescale 1ns/1ps
module mdt_decode_tb;
  import mdt_pkg::*;
  typedef struct {
    logic [7:0] op, spo, rpo, ppo;
    logic       ext, cnz, und, tk, ck;
    logic [4:0] cyc;
    logic [2:0] pipe;
    logic [1:0] len;  // Zero means length and pipeline are not checked
    logic [2:0] str;
  } mdt_row_t;
  logic       clock_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       issue_in = 1'b0;
  logic [7:0] opcode_in = 8'h00;
  logic       carry_in = 1'b0, zero_in = 1'b0, sign_in = 1'b0, ovf_in = 1'b0;
  logic [7:0] dst_in = 8'h00, src_in = 8'h00, sp_w, rp_w, pp_w;
  logic       count_nz_in = 1'b0, ext_timing_in = 1'b0, reset_high_in = 1'b0;
  logic       commit = 1'b0;
  logic       busy_out, done_out, undefined_out, taken_out, test_only_out;
  logic       zero_out, sign_out, ovf_out, carry_out, ext_mode_out;
  logic [4:0] cycles_out;
  logic [2:0] pipe_out, stretch_out;
  logic [1:0] length_out;
  logic [7:0] stack_ptr_out, reg_ptr_out, pair_ptr_out;
  int         fails = 0, num_checks = 0;
  // ---------------------------------------------------------------
  // Expected results: op, pointers, ext, cnz, und, tk, ck, cycles, pipe, len, stretch
  // ---------------------------------------------------------------
  mdt_row_t rows [15] = '{
    '{8'hC2, 8'h40, 8'h10, 8'h20, 0, 0, 0, 0, 0, 5'h0C, 3'h0, 2'h2, 3'h0},
    '{8'hC2, 8'h40, 8'h10, 8'h20, 1, 0, 0, 0, 0, 5'h0C, 3'h0, 2'h2, 3'h2},
    '{8'hC3, 8'h40, 8'h11, 8'h21, 1, 0, 0, 0, 1, 5'h12, 3'h0, 2'h2, 3'h2},
    '{8'h82, 8'h40, 8'h10, 8'h20, 1, 0, 0, 0, 0, 5'h0C, 3'h0, 2'h2, 3'h2},
    '{8'h83, 8'h40, 8'h11, 8'h21, 0, 0, 0, 0, 1, 5'h12, 3'h0, 2'h2, 3'h0},
    '{8'hD3, 8'h40, 8'h11, 8'h21, 1, 0, 0, 0, 1, 5'h12, 3'h0, 2'h2, 3'h2},
    '{8'hAF, 8'h42, 8'h10, 8'h20, 1, 0, 0, 0, 1, 5'h0E, 3'h0, 2'h1, 3'h0},
    '{8'h70, 8'h3F, 8'h10, 8'h20, 0, 0, 0, 0, 1, 5'h0A, 3'h1, 2'h2, 3'h0},
    '{8'h71, 8'h3F, 8'h10, 8'h20, 0, 0, 0, 0, 1, 5'h0C, 3'h1, 2'h2, 3'h0},
    '{8'hD4, 8'h40, 8'h10, 8'h20, 0, 0, 0, 0, 0, 5'h14, 3'h0, 2'h3, 3'h0},
    '{8'hD6, 8'h40, 8'h10, 8'h20, 0, 0, 0, 0, 0, 5'h14, 3'h0, 2'h3, 3'h0},
    '{8'h0A, 8'h40, 8'h10, 8'h20, 0, 1, 0, 1, 1, 5'h0C, 3'h5, 2'h2, 3'h0},
    '{8'h3A, 8'h40, 8'h10, 8'h20, 0, 0, 0, 0, 1, 5'h0A, 3'h5, 2'h2, 3'h0},
    '{8'h84, 8'h40, 8'h10, 8'h20, 0, 0, 1, 0, 1, 5'h06, 3'h0, 2'h0, 3'h0},
    '{8'h0F, 8'h40, 8'h10, 8'h20, 0, 0, 1, 0, 1, 5'h06, 3'h0, 2'h0, 3'h0}
  };
  // Free-running clock, 10 ns period
  always #5 clock_in = ~clock_in;
  mdt_ctx_model u_mdt_ctx_model (
    .clock_in (clock_in), .rst_in (rst_in), .commit_in (commit), .done_in (done_out),
    .sp_new_in (stack_ptr_out), .rp_new_in (reg_ptr_out), .pp_new_in (pair_ptr_out),
    .sp_out (sp_w), .rp_out (rp_w), .pp_out (pp_w)
  );
  mdt_decode u_mdt_decode (
    .clock_in (clock_in), .rst_in (rst_in), .issue_in (issue_in), .opcode_in (opcode_in),
    .carry_in (carry_in), .zero_in (zero_in), .sign_in (sign_in), .ovf_in (ovf_in),
    .dst_in (dst_in), .src_in (src_in), .stack_ptr_in (sp_w), .reg_ptr_in (rp_w),
    .pair_ptr_in (pp_w), .count_nz_in (count_nz_in), .ext_timing_in (ext_timing_in),
    .reset_high_in (reset_high_in), .busy_out (busy_out), .done_out (done_out),
    .cycles_out (cycles_out), .pipe_out (pipe_out), .length_out (length_out),
    .undefined_out (undefined_out), .taken_out (taken_out), .test_only_out (test_only_out),
    .zero_out (zero_out), .sign_out (sign_out), .ovf_out (ovf_out), .carry_out (carry_out),
    .stack_ptr_out (stack_ptr_out), .reg_ptr_out (reg_ptr_out),
    .pair_ptr_out (pair_ptr_out), .stretch_out (stretch_out), .ext_mode_out (ext_mode_out)
  );
  // Count a comparison and report a mismatch at once
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Issue one opcode and count edges until done; busy must rise at once.
  // n is the edge, counted from the issue edge, at which done is sampled high
  task automatic run(input logic [7:0] op, input logic ext, input logic cnz, output int n);
    opcode_in = op;
    ext_timing_in = ext;
    count_nz_in = cnz;
    issue_in = 1'b1;
    @(posedge clock_in);
    #1 issue_in = 1'b0;
    chk("busy", 8'h01, 8'(busy_out));
    for (n = 2; n <= 40; n++) begin
      @(posedge clock_in);
      #1;
      if (done_out === 1'b1) break;
    end
  endtask
  // Branch condition reference: upper half of the codes inverts the lower
  function automatic logic cref(input logic [3:0] cc, input logic c, z, s, v);
    logic b;
    case (cc[2:0])
      3'h0: b = 1'b0;
      3'h1: b = s ^ v;
      3'h2: b = z | (s ^ v);
      3'h3: b = c | z;
      3'h4: b = v;
      3'h5: b = s;
      3'h6: b = z;
      default: b = c;
    endcase
    return b ^ cc[3];
  endfunction
  task automatic results;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs well under 10000 cycles
  initial begin
    #200000;
    fails++;
    results();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int       n;
    logic [7:0] e;
    mdt_row_t r;
    repeat (10) @(posedge clock_in);
    #1 rst_in = 1'b0;
    chk("ext_mode", 8'h00, 8'(ext_mode_out));
    {carry_in, zero_in, sign_in, ovf_in} = 4'h9;
    foreach (rows[i]) begin
      r = rows[i];
      run(r.op, r.ext, r.cnz, n);
      chk("done_cycle", {3'h0, r.cyc} + {5'h00, r.str}, n[7:0]);
      chk("cycles", 8'(r.cyc), 8'(cycles_out));
      chk("stretch", 8'(r.str), 8'(stretch_out));
      chk("undefined", 8'(r.und), 8'(undefined_out));
      chk("flags", 8'h09, 8'({carry_out, zero_out, sign_out, ovf_out}));
      if (r.len != 2'h0) chk("length", 8'(r.len), 8'(length_out));
      if (r.len != 2'h0) chk("pipe", 8'(r.pipe), 8'(pipe_out));
      if (r.ck) chk("stack_ptr", r.spo, stack_ptr_out);
      if (r.ck) chk("ptrs", r.rpo ^ r.ppo, reg_ptr_out ^ pair_ptr_out);
      if (r.ck) chk("reg_ptr", r.rpo, reg_ptr_out);
      if (r.op[3:0] == LO_DECREMENT_BRANCH_NONZERO) chk("taken", 8'(r.tk), 8'(taken_out));
    end
    // Test operations over every addressing code and two operand pairs
    for (int k = 0; k < 24; k++) begin
      dst_in = k[0] ? 8'hFF : 8'hF0;
      src_in = k[0] ? 8'h0F : 8'h8F;
      e = k[1] ? (dst_in & src_in) : (~dst_in & src_in);
      {carry_in, zero_in, sign_in, ovf_in} = {1'b1, e != 8'h00, ~e[7], 1'b1};
      run({k[1] ? HI_MASK_TEST : HI_COMPLEMENT_MASK_TEST, 4'(k / 4 + 2)}, 1'b0, 1'b0, n);
      chk("test_flags", {4'h0, 1'b1, e == 8'h00, e[7], 1'b0},
          8'({carry_out, zero_out, sign_out, ovf_out}));
      chk("test_only", 8'h01, 8'(test_only_out));
      chk("test_cycles", (k < 8) ? 8'h06 : 8'h0A, 8'(cycles_out));
      chk("test_len", (k < 8) ? 8'h02 : 8'h03, 8'(length_out));
    end
    // Every condition code against every flag pattern; relative jump when V is clear, absolute when V is set
    for (int k = 0; k < 256; k++) begin
      {carry_in, zero_in, sign_in, ovf_in} = k[3:0];
      e = 8'(cref(k[7:4], k[3], k[2], k[1], k[0]));
      run({k[7:4], k[0] ? LO_JP : LO_JR}, 1'b0, 1'b0, n);
      chk("taken", e, 8'(taken_out));
      chk("branch_cycles", e[0] ? 8'h0C : 8'h0A, n[7:0]);
      chk("branch_pipe", 8'h00, 8'(pipe_out));
    end
    // Issue while busy is ignored: return still ends 14 edges after it began
    opcode_in = OP_SUB_EXIT;
    issue_in = 1'b1;
    for (n = 1; n < 40; n++) begin
      @(posedge clock_in);
      #1 issue_in = (n == 4);
      opcode_in = OP_PM_LOAD_AI;
      if (n > 1 && done_out === 1'b1) break;
    end
    chk("refused_done", 8'h0E, n[7:0]);
    chk("refused_cycles", 8'h0E, 8'(cycles_out));
    // Raised reset level selects external mode, which then stays set
    reset_high_in = 1'b1;
    rst_in = 1'b1;
    repeat (10) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (5) @(posedge clock_in);
    #1 reset_high_in = 1'b0;
    repeat (5) @(posedge clock_in);
    #1 chk("ext_mode", 8'h01, 8'(ext_mode_out));
    run(OP_STACK_PUSH_R, 1'b0, 1'b0, n);
    chk("push_r_ext", 8'h0C, n[7:0]);
    run(OP_STACK_PUSH_IR, 1'b0, 1'b0, n);
    chk("push_ir_ext", 8'h0E, n[7:0]);
    // Push then return with write-back: the pointer ends one above its start
    commit = 1'b1;
    run(OP_STACK_PUSH_R, 1'b0, 1'b0, n);
    @(posedge clock_in);
    #1 run(OP_SUB_EXIT, 1'b0, 1'b0, n);
    chk("chain_sp", 8'h41, stack_ptr_out);
    results();
  end
endmodule
